//--- sbl_params.svh
// Purpose: constants for the serial boot loader packet engine
// Assumes: included by its bare name
// Notes:   byte codes, command codes, status codes, packet lengths, memory range
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

`define SBL_ACK_BYTE        8'hcc
`define SBL_NAK_BYTE        8'h33
`define SBL_CMD_PING        8'h20
`define SBL_CMD_DOWNLOAD    8'h21
`define SBL_CMD_RUN         8'h22
`define SBL_CMD_STATUS      8'h23
`define SBL_CMD_SEND_DATA   8'h24
`define SBL_CMD_RESET       8'h25
`define SBL_LEN_PING        8'h03
`define SBL_LEN_DOWNLOAD    8'h0b
`define SBL_LEN_RUN         8'h07
`define SBL_LEN_STATUS      8'h03
`define SBL_LEN_RESET       8'h03
`define SBL_LEN_REPLY       8'h03
`define SBL_MAX_LEN         8'h0b
`define SBL_ST_SUCCESS      8'h40
`define SBL_ST_UNKNOWN_CMD  8'h41
`define SBL_ST_INVALID_CMD  8'h42
`define SBL_ST_INVALID_ADDR 8'h43
`define SBL_ST_FLASH_FAIL   8'h44
`define SBL_ST_RESET        8'h40
`define SBL_MEM_BASE        32'h0000_0000
`define SBL_MEM_SIZE        32'h0004_0000

`endif

//--- sbl_pkg.sv
// Purpose: types for the serial boot loader packet engine
// Assumes: nothing
// Notes:   one-hot engine states
package sbl_pkg;
  typedef enum logic [7:0] {
    SBL_IDLE  = 8'h01,
    SBL_RECV  = 8'h02,
    SBL_EXEC  = 8'h04,
    SBL_WAIT  = 8'h08,
    SBL_REPLY = 8'h10,
    SBL_SEND  = 8'h20,
    SBL_HACK  = 8'h40,
    SBL_POST  = 8'h80
  } sbl_state_t;
endpackage

//--- sbl_byte_if.sv
// Purpose: byte stream between engine and its transmit serialiser
// Assumes: single clock
// Notes:   valid/ready handshake
`timescale 1ns/1ns
interface sbl_byte_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- sbl_tx_stage.sv
// Purpose: registered transmit stage toward the serial port
// Assumes: serial port takes tx_data when tx_valid and tx_ready
// Notes:   one-byte holding register, tx_data and tx_valid straight from flops, up.ready combinational from tx_ready
`timescale 1ns/1ns
module sbl_tx_stage (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Engine side
  sbl_byte_if.snk         up,
  // Serial port side
  output logic [7:0]      tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  logic [7:0] data_q, data_d;
  logic       valid_q, valid_d;

  // Hold one byte until the port takes it
  always_comb begin
    data_d  = data_q;
    valid_d = valid_q;
    if (valid_q && tx_ready) begin
      valid_d = 1'b0;
    end
    if (up.valid && up.ready) begin
      data_d  = up.data;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_q  <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      data_q  <= data_d;
      valid_q <= valid_d;
    end
  end

  // Refill in the cycle the port takes the byte, so a packet has no idle gap
  assign up.ready = !valid_q || tx_ready;
  assign tx_data  = data_q;
  assign tx_valid = valid_q;
endmodule

//--- sbl_engine.sv
// Purpose: packet and command engine of a serial boot loader
// Assumes: byte port below delivers received bytes as one-cycle strobes
// Notes:   erase and program are done by an outside flash controller
// Operation
// - First byte is total packet length
// - Second byte is payload sum, compared
// - Reply 0xcc on success, 0x33 on failure
// - Accept means reception only, status separate; a flash failure on download or data-send replies 0x33
// - Returned packet sent without gaps after length
// - Device skips zeros before host response
// - First payload byte is command code
// - Ping accepted, status set to success
// - Status query returns one status byte
// - Download carries address and count, MSB first
// - Download erases region before replying
// - Download range checked, reported via status
// - Data-send programs bytes, advances address
// - Session ends at announced byte count
// - Rejected data-send keeps address unchanged
// - Run replies accept, then starts execution
// - Reset replies accept, then resets device
`timescale 1ns/1ns
`include "sbl_params.svh"
module sbl_engine (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Received byte stream
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // Transmit byte stream
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Flash controller
  output logic             erase_start,
  output logic [31:0]      erase_addr,
  output logic [31:0]      erase_size,
  output logic             prog_start,
  output logic [31:0]      prog_addr,
  output logic [63:0]      prog_data,
  output logic [3:0]       prog_count,
  input  wire logic        flash_done,
  input  wire logic        flash_error,
  // System control
  output logic             run_start,
  output logic [31:0]      run_addr,
  output logic             soft_reset,
  output logic             session_active
);
  sbl_byte_if tx_if ();

  sbl_pkg::sbl_state_t state_q, state_d;
  logic [7:0]  buf_q [0:10];
  logic [7:0]  buf_d [0:10];
  logic [7:0]  len_q, len_d, idx_q, idx_d, sum_q, sum_d, status_q, status_d;
  logic [7:0]  reply_q, reply_d;
  logic [1:0]  post_q, post_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [31:0] addr_q, addr_d, left_q, left_d, run_addr_q, run_addr_d;
  logic        sess_q, sess_d, may_send_q, may_send_d;
  logic        erase_q, erase_d, prog_q, prog_d, run_q, run_d, rst_q, rst_d;
  logic [7:0]  txb;
  logic        txv;

  // Gather four buffer bytes MSB first
  function automatic logic [31:0] word_at(input int base);
    word_at = {buf_q[base], buf_q[base+1], buf_q[base+2], buf_q[base+3]};
  endfunction

  // Range lies inside flash
  function automatic logic range_ok(input logic [31:0] a, input logic [31:0] n);
    logic [32:0] e;
    e = {1'b0, a} + {1'b0, n};
    range_ok = (a >= `SBL_MEM_BASE) && (e <= {1'b0, `SBL_MEM_BASE} + {1'b0, `SBL_MEM_SIZE});
  endfunction

  // Next-state logic of the engine
  always_comb begin
    state_d = state_q;
    buf_d = buf_q;
    len_d = len_q;
    idx_d = idx_q;
    sum_d = sum_q;
    status_d = status_q;
    reply_d = reply_q;
    post_d = post_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    left_d = left_q;
    run_addr_d = run_addr_q;
    sess_d = sess_q;
    may_send_d = may_send_q;
    erase_d = 1'b0;
    prog_d = 1'b0;
    run_d = 1'b0;
    rst_d = rst_q;
    txb = 8'h00;
    txv = 1'b0;
    unique case (state_q)
      sbl_pkg::SBL_IDLE: begin
        if (rx_valid && rx_data != 8'h00) begin
          len_d = rx_data;
          idx_d = 8'h01;
          sum_d = 8'h00;
          state_d = sbl_pkg::SBL_RECV;
        end
      end
      sbl_pkg::SBL_RECV: begin
        if (rx_valid) begin
          if (idx_q <= `SBL_MAX_LEN - 8'h01) begin
            buf_d[idx_q[3:0]] = rx_data;
          end
          if (idx_q >= 8'h02) begin
            sum_d = sum_q + rx_data;
          end
          idx_d = idx_q + 8'h01;
          if (idx_q + 8'h01 == len_q) begin
            state_d = sbl_pkg::SBL_EXEC;
          end
        end
      end
      sbl_pkg::SBL_EXEC: begin
        post_d = 2'd0;
        state_d = sbl_pkg::SBL_REPLY;
        if (len_q < 8'h03 || len_q > `SBL_MAX_LEN || sum_q != buf_q[1]) begin
          reply_d = `SBL_NAK_BYTE;
        end else begin
          reply_d = `SBL_ACK_BYTE;
          may_send_d = 1'b0;
          unique case (buf_q[2])
            `SBL_CMD_PING: status_d = `SBL_ST_SUCCESS;
            `SBL_CMD_STATUS: begin
              post_d = 2'd1;
              may_send_d = may_send_q;
            end
            `SBL_CMD_DOWNLOAD: begin
              if (len_q != `SBL_LEN_DOWNLOAD) begin
                status_d = `SBL_ST_INVALID_CMD;
              end else if (!range_ok(word_at(3), word_at(7))) begin
                status_d = `SBL_ST_INVALID_ADDR;
              end else begin
                addr_d = word_at(3);
                left_d = word_at(7);
                sess_d = 1'b1;
                may_send_d = 1'b1;
                erase_d = 1'b1;
                state_d = sbl_pkg::SBL_WAIT;
              end
            end
            `SBL_CMD_SEND_DATA: begin
              if (!may_send_q || !sess_q) begin
                status_d = `SBL_ST_INVALID_CMD;
              end else begin
                prog_d = 1'b1;
                cnt_d = len_q[3:0] - 4'd3;
                may_send_d = 1'b1;
                state_d = sbl_pkg::SBL_WAIT;
              end
            end
            `SBL_CMD_RUN: begin
              run_addr_d = word_at(3);
              status_d = `SBL_ST_SUCCESS;
              post_d = 2'd2;
            end
            `SBL_CMD_RESET: post_d = 2'd3;
            default: status_d = `SBL_ST_UNKNOWN_CMD;
          endcase
        end
      end
      sbl_pkg::SBL_WAIT: begin
        if (flash_done) begin
          state_d = sbl_pkg::SBL_REPLY;
          if (flash_error) begin
            status_d = `SBL_ST_FLASH_FAIL;
            reply_d = `SBL_NAK_BYTE;
            may_send_d = 1'b1;
          end else begin
            status_d = `SBL_ST_SUCCESS;
            if (buf_q[2] == `SBL_CMD_SEND_DATA) begin
              addr_d = addr_q + {24'h0, len_q - 8'h03};
              if (left_q <= {24'h0, len_q - 8'h03}) begin
                left_d = 32'h0;
                sess_d = 1'b0;
                may_send_d = 1'b0;
              end else begin
                left_d = left_q - {24'h0, len_q - 8'h03};
              end
            end
          end
        end
      end
      sbl_pkg::SBL_REPLY: begin
        txb = reply_q;
        txv = 1'b1;
        if (tx_if.ready) begin
          idx_d = 8'h00;
          state_d = (post_q == 2'd0 || reply_q == `SBL_NAK_BYTE) ?
                    sbl_pkg::SBL_IDLE : sbl_pkg::SBL_POST;
          if (post_q == 2'd1 && reply_q == `SBL_ACK_BYTE) begin
            state_d = sbl_pkg::SBL_SEND;
          end
        end
      end
      sbl_pkg::SBL_SEND: begin
        unique case (idx_q[1:0])
          2'd0: txb = `SBL_LEN_REPLY;
          2'd1: txb = status_q;
          default: txb = status_q;
        endcase
        txv = 1'b1;
        if (tx_if.ready) begin
          idx_d = idx_q + 8'h01;
          if (idx_q == 8'h02) begin
            state_d = sbl_pkg::SBL_HACK;
          end
        end
      end
      sbl_pkg::SBL_HACK: begin
        if (rx_valid && rx_data != 8'h00) begin
          state_d = sbl_pkg::SBL_IDLE;
        end
      end
      sbl_pkg::SBL_POST: begin
        // Act only once the port takes the reply byte
        if (tx_if.ready) begin
          if (post_q == 2'd2) begin
            run_d = 1'b1;
          end else begin
            rst_d = 1'b1;
          end
          state_d = sbl_pkg::SBL_IDLE;
        end
      end
      default: state_d = sbl_pkg::SBL_IDLE;
    endcase
  end

  // Register the engine state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= sbl_pkg::SBL_IDLE;
      for (int i = 0; i < 11; i++) begin
        buf_q[i] <= 8'h00;
      end
      len_q <= 8'h00;
      idx_q <= 8'h00;
      sum_q <= 8'h00;
      status_q <= `SBL_ST_RESET;
      reply_q <= `SBL_ACK_BYTE;
      post_q <= 2'd0;
      cnt_q <= 4'h0;
      addr_q <= 32'h0;
      left_q <= 32'h0;
      run_addr_q <= 32'h0;
      sess_q <= 1'b0;
      may_send_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
      run_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      buf_q <= buf_d;
      len_q <= len_d;
      idx_q <= idx_d;
      sum_q <= sum_d;
      status_q <= status_d;
      reply_q <= reply_d;
      post_q <= post_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      left_q <= left_d;
      run_addr_q <= run_addr_d;
      sess_q <= sess_d;
      may_send_q <= may_send_d;
      erase_q <= erase_d;
      prog_q <= prog_d;
      run_q <= run_d;
      rst_q <= rst_d;
    end
  end

  // Feed transmit stage
  assign tx_if.data  = txb;
  assign tx_if.valid = txv;

  sbl_tx_stage u_tx (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .up       (tx_if),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready)
  );

  // Flash and system outputs from flops
  assign erase_start    = erase_q;
  assign erase_addr     = addr_q;
  assign erase_size     = left_q;
  assign prog_start     = prog_q;
  assign prog_addr      = addr_q;
  assign prog_data      = {buf_q[3], buf_q[4], buf_q[5], buf_q[6],
                           buf_q[7], buf_q[8], buf_q[9], buf_q[10]};
  assign prog_count     = cnt_q;
  assign run_start      = run_q;
  assign run_addr       = run_addr_q;
  assign soft_reset     = rst_q;
  assign session_active = sess_q;
endmodule

//--- sbl_engine_props.sv
// Purpose: port assertions for the packet engine
// Assumes: bound onto sbl_engine, one clock domain
// Notes:   sees only engine ports
`timescale 1ns/1ns
module sbl_engine_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // Byte streams
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  // Flash and system
  input wire logic       erase_start,
  input wire logic       prog_start,
  input wire logic       flash_done,
  input wire logic       run_start,
  input wire logic       soft_reset,
  input wire logic       session_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_tx_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte changed early");
  a_ping_ack_time: assert property (
    rx_valid && rx_data == 8'h03 ##1 rx_valid && rx_data == 8'h20 ##1 rx_valid && rx_data == 8'h20
    |-> ##3 (tx_valid && tx_data == 8'hcc)) else $error("ping reply late or wrong");
  a_flash_reply_time: assert property (
    flash_done |-> ##2 (tx_valid && (tx_data == 8'hcc || tx_data == 8'h33)))
    else $error("reply not two cycles after flash done");
  a_erase_one_pulse: assert property (erase_start |=> !erase_start)
    else $error("erase start longer than one cycle");
  a_prog_one_pulse: assert property (prog_start |=> !prog_start && !erase_start)
    else $error("program start longer than one cycle");
  a_run_after_reply: assert property (run_start |-> !tx_valid ##1 !run_start)
    else $error("run start while reply pending");
  a_soft_reset_after: assert property ($rose(soft_reset) |-> !tx_valid)
    else $error("soft reset before reply sent");
  a_soft_reset_holds: assert property (soft_reset |=> soft_reset)
    else $error("soft reset dropped");
  a_reset_quiets: assert property (disable iff (1'b0)
    reset |=> !tx_valid && !session_active && !soft_reset) else $error("outputs live after reset");
endmodule

//--- sbl_host_model.sv
// Purpose: host side of the serial link, taking device bytes
// Assumes: bench sends host packets itself
// Notes:   slow mode accepts every other cycle
`timescale 1ns/1ns
module sbl_host_model (
  // Clock
  input wire logic        sys_clk,
  // Device transmit stream
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  output logic            tx_ready,
  // Bench control and view
  input wire logic        slow,
  output logic [7:0]      got_byte,
  output int              got_cnt
);
  logic phase = 1'b0;
  initial begin
    tx_ready = 1'b1;
    got_byte = 8'h00;
    got_cnt = 0;
  end
  // Ready pacing, changed off the sampling edge
  always @(negedge sys_clk) begin
    phase = ~phase;
    tx_ready = !slow || phase;
  end
  // Zero padding skipped, each nonzero byte kept and counted
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready && tx_data != 8'h00) begin
      got_byte <= tx_data;
      got_cnt <= got_cnt + 1;
    end
  end
endmodule

//--- serial_boot_loader_packet_engine_tb.sv
// Purpose: self-checking bench for the packet engine
// Assumes: flash stand-in answers five cycles after a start
// Notes:   host packets built here, replies seen through the host model
`timescale 1ns/1ns
`include "sbl_params.svh"
module serial_boot_loader_packet_engine_tb;
  logic        sys_clk = 1'b0, reset = 1'b1, rx_valid = 1'b0, tx_ready, slow = 1'b0;
  logic        flash_done = 1'b0, flash_error = 1'b0, tx_valid, erase_start, prog_start;
  logic        run_start, soft_reset, session_active;
  logic [7:0]  rx_data = 8'h00, tx_data, got_byte;
  logic [31:0] erase_addr, erase_size, prog_addr, run_addr, c_ea, c_es, c_pa, c_ra;
  logic [63:0] prog_data, c_pd;
  logic [3:0]  prog_count, c_pc;
  int          got_cnt, fails = 0, samples_checked = 0, fcnt = 0;

  always #50 sys_clk = ~sys_clk;

  sbl_engine uut (.sys_clk(sys_clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .erase_start(erase_start),
    .erase_addr(erase_addr), .erase_size(erase_size), .prog_start(prog_start),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_count(prog_count),
    .flash_done(flash_done), .flash_error(flash_error), .run_start(run_start),
    .run_addr(run_addr), .soft_reset(soft_reset), .session_active(session_active));

  sbl_host_model host (.sys_clk(sys_clk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .slow(slow), .got_byte(got_byte), .got_cnt(got_cnt));

  // Flash stand-in: done pulse five cycles after a start
  always @(negedge sys_clk) begin
    flash_done <= 1'b0;
    if (erase_start || prog_start) fcnt = 5;
    else if (fcnt > 0) begin
      fcnt = fcnt - 1;
      if (fcnt == 0) flash_done <= 1'b1;
    end
  end
  // Capture of start pulse payloads
  always @(posedge sys_clk) begin
    if (erase_start) {c_ea, c_es} <= {erase_addr, erase_size};
    if (prog_start) {c_pa, c_pd, c_pc} <= {prog_addr, prog_data, prog_count};
    if (run_start) c_ra <= run_addr;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic raw(input logic [7:0] p[$]);
    foreach (p[i]) begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data = p[i];
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
  endtask
  task automatic send(input logic [7:0] p[$], input bit bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (p[i]) s = s + p[i];
    p.push_front(s ^ {7'h00, bad});
    p.push_front(8'(p.size() + 1));
    raw(p);
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    int n0, k;
    n0 = got_cnt;
    for (k = 0; k < 200 && got_cnt == n0; k++) @(negedge sys_clk);
    if (got_cnt == n0) begin
      fails++;
      close_out();
    end else begin
      chk({56'h0, got_byte}, {56'h0, exp});
    end
  endtask
  task automatic status(input logic [7:0] st, input logic [7:0] host_reply);
    send('{`SBL_CMD_STATUS}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    expect_byte(8'h03);
    expect_byte(st);
    expect_byte(st);
    raw('{8'h00, 8'h00, host_reply});
  endtask

  task automatic t_ping();
    raw('{8'h00, 8'h00});
    send('{`SBL_CMD_PING}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    status(`SBL_ST_SUCCESS, `SBL_NAK_BYTE);
    status(`SBL_ST_SUCCESS, `SBL_ACK_BYTE);
    $display("test ping done");
  endtask
  task automatic t_errors();
    send('{`SBL_CMD_PING}, 1'b1);
    expect_byte(`SBL_NAK_BYTE);
    raw('{8'h02, 8'h00});
    expect_byte(`SBL_NAK_BYTE);
    send('{8'h7e}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    status(`SBL_ST_UNKNOWN_CMD, `SBL_ACK_BYTE);
    send('{`SBL_CMD_SEND_DATA, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    status(`SBL_ST_INVALID_CMD, `SBL_ACK_BYTE);
    $display("test errors done");
  endtask
  task automatic t_download();
    slow = 1'b1;
    send('{`SBL_CMD_DOWNLOAD, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    chk({c_ea, c_es}, 64'h0000_0100_0000_0010);
    status(`SBL_ST_SUCCESS, `SBL_ACK_BYTE);
    send('{`SBL_CMD_SEND_DATA, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
           8'h18}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    chk({c_pa, 28'h0, c_pc}, 64'h0000_0100_0000_0008);
    chk(c_pd, 64'h1112_1314_1516_1718);
    chk({63'h0, session_active}, 64'h1);
    flash_error = 1'b1;
    send('{`SBL_CMD_SEND_DATA, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28}, 1'b0);
    expect_byte(`SBL_NAK_BYTE);
    flash_error = 1'b0;
    send('{`SBL_CMD_SEND_DATA, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    chk({c_pa, c_pd[31:0]}, 64'h0000_0108_2526_2728);
    slow = 1'b0;
    status(`SBL_ST_SUCCESS, `SBL_ACK_BYTE);
    chk({63'h0, session_active}, 64'h0);
    $display("test download done");
  endtask
  task automatic t_badaddr();
    send('{`SBL_CMD_DOWNLOAD, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    status(`SBL_ST_INVALID_ADDR, `SBL_ACK_BYTE);
    $display("test bad address done");
  endtask
  task automatic t_run_reset();
    int k;
    send('{`SBL_CMD_RUN, 8'h00, 8'h00, 8'h02, 8'h00}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    for (k = 0; k < 20 && c_ra !== 32'h200; k++) @(negedge sys_clk);
    chk({32'h0, c_ra}, 64'h200);
    send('{`SBL_CMD_RESET}, 1'b0);
    expect_byte(`SBL_ACK_BYTE);
    for (k = 0; k < 20 && soft_reset !== 1'b1; k++) @(negedge sys_clk);
    chk({63'h0, soft_reset}, 64'h1);
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    chk({62'h0, soft_reset, session_active}, 64'h0);
    $display("test run and reset done");
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    t_ping();
    t_errors();
    t_download();
    t_badaddr();
    t_run_reset();
    close_out();
  end
endmodule

bind sbl_engine sbl_engine_props u_props (.sys_clk(sys_clk), .reset(reset), .rx_data(rx_data),
  .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .erase_start(erase_start), .prog_start(prog_start), .flash_done(flash_done),
  .run_start(run_start), .soft_reset(soft_reset), .session_active(session_active));
